/* verilog/meas_handshake_pkg.sv */
// Purpose: shared constants and types for the measurement handshake block
// Assumes: 20 MHz system clock; all times held in microseconds
// Notes: cycle counts are derived inside the block from US_CYCLES
package meas_handshake_pkg;

    // ==========================================================
    // clock
    localparam int CLOCK_HZ = 20_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int US_CYCLES_DEFAULT = CLOCK_HZ / US_PER_S;
    localparam logic [19:0] US_PER_MS = 20'h003E8;

    // ==========================================================
    // controller side timing, kept for the bench
    localparam logic [19:0] MEAS_TRIGGER_MIN_WIDTH_US = 20'h001F4;
    localparam logic [19:0] SETTLE_US = 20'h00BB8;
    localparam logic [19:0] FAULT_RESPONSE_US = 20'h005DC;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // measurement interval, single quantity
    localparam logic [19:0] MEAS_S_FASTEST_US = 20'h00D48;
    localparam logic [19:0] MEAS_S_FAST_US = 20'h02C88;
    localparam logic [19:0] MEAS_S_MED50_US = 20'h0A1B8;
    localparam logic [19:0] MEAS_S_MED60_US = 20'h08660;
    localparam logic [19:0] MEAS_S_SLOW50_US = 20'h262F0;
    localparam logic [19:0] MEAS_S_SLOW60_US = 20'h24928;
    // measurement interval, dual quantity
    localparam logic [19:0] MEAS_D_FASTEST_US = 20'h01A90;
    localparam logic [19:0] MEAS_D_FAST_US = 20'h05910;
    localparam logic [19:0] MEAS_D_MED50_US = 20'h14370;
    localparam logic [19:0] MEAS_D_MED60_US = 20'h10CC0;
    localparam logic [19:0] MEAS_D_SLOW50_US = 20'h3EF08;
    localparam logic [19:0] MEAS_D_SLOW60_US = 20'h3D540;
    // averaging overhead
    localparam logic [19:0] OVH_S_US = 20'h00578;
    localparam logic [19:0] OVH_D_US = 20'h00AF0;
    localparam logic [19:0] OVH_S_SLOW50_US = 20'h0DC50;
    localparam logic [19:0] OVH_S_SLOW60_US = 20'h0C288;
    localparam logic [19:0] OVH_D_SLOW50_US = 20'h0E1C8;
    localparam logic [19:0] OVH_D_SLOW60_US = 20'h0C800;

    // ==========================================================
    // calculation interval
    localparam logic [19:0] CALC_BASE_US = 20'h0012C;
    localparam logic [19:0] CALC_STATS_US = 20'h0012C;
    localparam logic [19:0] CALC_REFTOL_US = 20'h00096;

    // ==========================================================
    // end-of-conversion hold under internal triggering
    localparam logic [19:0] EOC_INT_FASTEST_US = 20'h003E8;
    localparam logic [19:0] EOC_INT_FAST_US = 20'h01388;
    localparam logic [19:0] EOC_INT_MEDIUM_US = 20'h04E20;
    localparam logic [19:0] EOC_INT_SLOW_US = 20'h0C350;

    // ==========================================================
    // reset values
    localparam logic EOC_RESET = 1'b1;
    localparam logic READY_RESET = 1'b1;
    localparam logic FAULT_RESET = 1'b0;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        MODE_DUAL = 2'h0,
        MODE_RES = 2'h1,
        MODE_VOLT = 2'h2
    } mode_t;

    typedef enum logic [1:0] {
        RATE_FASTEST = 2'h0,
        RATE_FAST = 2'h1,
        RATE_MEDIUM = 2'h2,
        RATE_SLOW = 2'h3
    } rate_t;

    typedef struct packed {
        logic extTrigger;
        logic eocPulse;
        logic faultModeLive;
        rate_t rate;
        mode_t mode;
        logic line60;
        logic statsOn;
        logic refTol;
    } cfg_t;

    typedef struct packed {
        logic high;
        logic inRange;
        logic low;
    } judge_t;

endpackage

/* verilog/meas_handshake_outputs.sv */
// Purpose: measurement cycle sequencer and control port output drivers
// Assumes: one clock, asynchronous active low reset, pins synchronised here
// Notes: outputs are logical levels; open-drain drive sits outside
`timescale 1ns/1ps
`default_nettype none

module meas_handshake_outputs
    import meas_handshake_pkg::*;
#(
    parameter int US_CYCLES = US_CYCLES_DEFAULT,
    parameter int AVG_W = 8,
    parameter int GP_W = 10
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire cfg_t cfg,
    input wire logic [AVG_W-1:0] avgCount,
    input wire logic [19:0] delayUs,
    input wire logic [7:0] eocPulseMs,
    input wire logic calActive,
    input wire logic measTrigger,
    input wire logic probeFault,
    input wire judge_t resJudge,
    input wire judge_t voltJudge,
    input wire logic gpWrite,
    input wire logic [GP_W-1:0] gpData,
    output logic eoc,
    output logic removalReady,
    output logic faultOut,
    output judge_t resOut,
    output judge_t voltOut,
    output logic combinedPass,
    output logic [GP_W-1:0] gpOutputs
);

    // ==========================================================
    // types and helpers
    typedef enum logic [4:0] {
        ST_WAIT = 5'h01,
        ST_DELAY = 5'h02,
        ST_MEAS = 5'h04,
        ST_CALC = 5'h08,
        ST_SELFCAL = 5'h10
    } state_t;

    // microseconds to a down-count that ends at zero
    function automatic logic [31:0] toCount(input logic [31:0] us);
        logic [31:0] cyc;
        cyc = us * 32'(US_CYCLES);
        toCount = (cyc == 32'h0) ? 32'h0 : cyc - 32'h1;
    endfunction

    function automatic logic [19:0] measBaseUs(input cfg_t c);
        logic dual;
        dual = (c.mode == MODE_DUAL);
        case (c.rate)
            RATE_FASTEST: measBaseUs = dual ? MEAS_D_FASTEST_US :
                MEAS_S_FASTEST_US;
            RATE_FAST: measBaseUs = dual ? MEAS_D_FAST_US : MEAS_S_FAST_US;
            RATE_MEDIUM: begin
                if (dual) begin
                    measBaseUs = c.line60 ? MEAS_D_MED60_US : MEAS_D_MED50_US;
                end else begin
                    measBaseUs = c.line60 ? MEAS_S_MED60_US : MEAS_S_MED50_US;
                end
            end
            default: begin
                if (dual) begin
                    measBaseUs = c.line60 ? MEAS_D_SLOW60_US :
                        MEAS_D_SLOW50_US;
                end else begin
                    measBaseUs = c.line60 ? MEAS_S_SLOW60_US :
                        MEAS_S_SLOW50_US;
                end
            end
        endcase
    endfunction

    function automatic logic [19:0] overheadUs(input cfg_t c);
        logic dual;
        dual = (c.mode == MODE_DUAL);
        if (c.rate != RATE_SLOW) begin
            overheadUs = dual ? OVH_D_US : OVH_S_US;
        end else if (dual) begin
            overheadUs = c.line60 ? OVH_D_SLOW60_US : OVH_D_SLOW50_US;
        end else begin
            overheadUs = c.line60 ? OVH_S_SLOW60_US : OVH_S_SLOW50_US;
        end
    endfunction

    // ==========================================================
    // pin synchronisers
    logic trigMeta;
    logic trigSync;
    logic trigLast;
    logic faultMeta;
    logic faultLive;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            trigMeta <= 1'b1;
            trigSync <= 1'b1;
            trigLast <= 1'b1;
        end else begin
            trigMeta <= measTrigger;
            trigSync <= trigMeta;
            trigLast <= trigSync;
        end
    end

    // two stages keep the live fault well inside its response time
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            faultMeta <= 1'b0;
            faultLive <= 1'b0;
        end else begin
            faultMeta <= probeFault;
            faultLive <= faultMeta;
        end
    end

    // ==========================================================
    // sequencer
    state_t state;
    state_t next_state;
    logic [31:0] phaseCount;
    logic [19:0] eocCount;
    logic [31:0] eocLoad;
    logic phaseDone;
    logic trigFall;
    logic trigAccept;
    logic calcDone;
    logic [31:0] measUs;
    logic [31:0] calcUs;
    logic [AVG_W-1:0] avgN;

    assign phaseDone = (phaseCount == 32'h0);
    assign trigFall = trigLast & ~trigSync;
    // internal mode restarts once the end flag period has run out
    assign trigAccept = (state == ST_WAIT) && !calActive &&
        (cfg.extTrigger ? trigFall : !eoc);
    assign calcDone = (state == ST_CALC) && phaseDone;
    assign avgN = (avgCount == '0) ? AVG_W'(1) : avgCount;

    always_comb begin
        measUs = 32'(measBaseUs(cfg));
        if (cfg.extTrigger) begin
            measUs = 32'(measBaseUs(cfg) - overheadUs(cfg)) * 32'(avgN) +
                32'(overheadUs(cfg));
        end
    end // internal mode keeps the base time

    always_comb begin
        calcUs = 32'(CALC_BASE_US);
        if (cfg.statsOn) begin
            calcUs = calcUs + 32'(CALC_STATS_US);
        end
        if (cfg.refTol) begin
            calcUs = calcUs + 32'(CALC_REFTOL_US);
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_WAIT: begin
                if (calActive) begin
                    next_state = ST_SELFCAL;
                end else if (trigAccept) begin
                    next_state = ST_DELAY;
                end
            end
            ST_DELAY: next_state = phaseDone ? ST_MEAS : ST_DELAY;
            ST_MEAS: next_state = phaseDone ? ST_CALC : ST_MEAS;
            ST_CALC: next_state = phaseDone ? ST_WAIT : ST_CALC;
            ST_SELFCAL: next_state = calActive ? ST_SELFCAL : ST_WAIT;
            default: next_state = ST_WAIT;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_WAIT;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phaseCount <= 32'h0;
        end else if (state == ST_WAIT && trigAccept) begin
            phaseCount <= toCount(32'(delayUs));
        end else if (!phaseDone) begin
            phaseCount <= phaseCount - 32'h1;
        end else if (state == ST_DELAY) begin
            phaseCount <= toCount(measUs);
        end else if (state == ST_MEAS) begin
            phaseCount <= toCount(calcUs);
        end
    end

    // ==========================================================
    // end flag and removal indicator
    always_comb begin
        eocLoad = 32'h0;
        if (cfg.eocPulse) begin
            eocLoad = 32'(eocPulseMs) * 32'(US_PER_MS);
        end else if (!cfg.extTrigger) begin
            case (cfg.rate)
                RATE_FASTEST: eocLoad = 32'(EOC_INT_FASTEST_US);
                RATE_FAST: eocLoad = 32'(EOC_INT_FAST_US);
                RATE_MEDIUM: eocLoad = 32'(EOC_INT_MEDIUM_US);
                default: eocLoad = 32'(EOC_INT_SLOW_US);
            endcase
        end
    end

    // width counter ticks in microseconds to stay narrow
    logic [7:0] usTick;
    logic usStep;
    assign usStep = (usTick == 8'(US_CYCLES - 1));

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            usTick <= 8'h00;
        end else if (calcDone || usStep) begin
            usTick <= 8'h00;
        end else begin
            usTick <= usTick + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            eocCount <= 20'h00000;
        end else if (calcDone) begin
            eocCount <= eocLoad[19:0];
        end else if (usStep && eocCount != 20'h00000) begin
            eocCount <= eocCount - 20'h00001;
        end
    end

    // a completion always wins over any clearing condition
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            eoc <= EOC_RESET;
        end else if (calcDone) begin
            eoc <= 1'b1;
        end else if (trigAccept) begin
            eoc <= 1'b0;
        end else if ((cfg.eocPulse || !cfg.extTrigger) &&
                eocCount == 20'h00000) begin
            eoc <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            removalReady <= READY_RESET;
        end else begin
            removalReady <= (next_state != ST_MEAS);
        end
    end

    // ==========================================================
    // fault output
    logic faultSeen;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            faultSeen <= 1'b0;
        end else if (state == ST_MEAS && faultLive) begin
            faultSeen <= 1'b1;
        end else if (state == ST_DELAY && phaseDone) begin
            faultSeen <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            faultOut <= FAULT_RESET;
        end else if (cfg.faultModeLive) begin
            faultOut <= faultLive;
        end else if (calcDone) begin
            faultOut <= faultSeen;
        end
    end

    // ==========================================================
    // judgments and general outputs
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            resOut <= '0;
            voltOut <= '0;
            combinedPass <= 1'b0;
        end else if (calcDone) begin
            resOut <= resJudge;
            voltOut <= voltJudge;
            case (cfg.mode)
                MODE_RES: combinedPass <= resJudge.inRange;
                MODE_VOLT: combinedPass <= voltJudge.inRange;
                default: combinedPass <= resJudge.inRange &
                    voltJudge.inRange;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gpOutputs <= '0;
        end else if (gpWrite) begin
            gpOutputs <= gpData;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    ext_meas_trigger_start_a: assert property (
        cfg.extTrigger && state == ST_WAIT && !calActive && trigFall
        |=> state == ST_DELAY)
        else $error("external trigger edge not accepted");
    int_meas_trigger_ignored_a: assert property (
        !cfg.extTrigger && eoc && state == ST_WAIT |=> state != ST_DELAY)
        else $error("trigger taken while end flag active");
    meas_to_calc_a: assert property (
        state == ST_MEAS |=> state == ST_MEAS || state == ST_CALC)
        else $error("measuring left to wrong state");
    eoc_after_calc_a: assert property (
        $rose(eoc) |-> $past(state) == ST_CALC)
        else $error("end flag rose outside calculation end");
    ready_low_meas_a: assert property (
        state == ST_MEAS |-> !removalReady)
        else $error("removal ready high while measuring");
    sync_fault_a: assert property (
        !cfg.faultModeLive && calcDone |=> faultOut == $past(faultSeen))
        else $error("sync fault not taken at completion");
    live_fault_a: assert property (
        cfg.faultModeLive && $past(cfg.faultModeLive)
        |-> faultOut == $past(faultLive))
        else $error("live fault not following contact");
    ext_hold_a: assert property (
        eoc && cfg.extTrigger && !cfg.eocPulse && !trigAccept |=> eoc)
        else $error("held end flag dropped without trigger");
    pass_dual_a: assert property (
        calcDone && cfg.mode == MODE_DUAL
        |=> combinedPass == (resOut.inRange & voltOut.inRange))
        else $error("combined pass wrong in dual mode");
    gp_write_a: assert property (
        gpWrite |=> gpOutputs == $past(gpData))
        else $error("general outputs not updated");

endmodule

`default_nettype wire

/* dv/meas_ctrl_model.sv */
// Purpose: controller model that drives the trigger pin of the block
// Assumes: bench asks for one trigger with a one-cycle fire request
// Notes: the pin idles high and only moves on falling clock edges
`timescale 1ns/1ps
`default_nettype none

module meas_ctrl_model #(
    parameter int SETTLE_CYC = 3001,
    parameter int WIDTH_CYC = 500
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic fire,
    output logic measTrigger
);
    // ==========================================================
    // trigger sequence
    initial begin
        measTrigger = 1'b1;
        forever begin
            @(negedge mclk);
            if (fire === 1'b1 && resetn === 1'b1) begin
                // new object contacted: readings need time to settle
                repeat (SETTLE_CYC) @(negedge mclk);
                measTrigger = 1'b0;
                repeat (WIDTH_CYC) @(negedge mclk);
                measTrigger = 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

/* dv/meas_handshake_outputs_bench.sv */
// Purpose: self-checking bench for the handshake output block
// Assumes: US_CYCLES of 1, so every microsecond is one clock
// Notes: slow rate left out to keep the run short
`timescale 1ns/1ps
`default_nettype none

module meas_handshake_outputs_bench;
    import meas_handshake_pkg::*;
    localparam int USC = 1;
    logic mclk, resetn, calActive, probeFault, gpWrite, fire, liveFault;
    logic measTrigger, eoc, removalReady, faultOut, combinedPass;
    // edge history starts at the reset levels, so reset gives no false edge
    logic prevEoc = 1'b1;
    logic prevRr = 1'b1;
    logic prevTrig = 1'b1;
    cfg_t cfg;
    logic [7:0] avgCount, eocPulseMs;
    logic [19:0] delayUs;
    logic [9:0] gpData, gpOutputs, d;
    judge_t resJudge, voltJudge, resOut, voltOut;
    int errCount, nTests, cyc, faultPlan, w, r0;
    int eocRise, eocFall, rrRise, rrFall, pinFall;
    int nEocRise, nEocFall, nRrRise, nRrFall;

    meas_handshake_outputs #(.US_CYCLES(USC)) u_meas_handshake_outputs (
        .mclk(mclk), .resetn(resetn), .cfg(cfg), .avgCount(avgCount),
        .delayUs(delayUs), .eocPulseMs(eocPulseMs), .calActive(calActive),
        .measTrigger(measTrigger), .probeFault(probeFault),
        .resJudge(resJudge), .voltJudge(voltJudge), .gpWrite(gpWrite),
        .gpData(gpData), .eoc(eoc), .removalReady(removalReady),
        .faultOut(faultOut), .resOut(resOut), .voltOut(voltOut),
        .combinedPass(combinedPass), .gpOutputs(gpOutputs)
    );
    meas_ctrl_model #(.SETTLE_CYC(int'(SETTLE_US) * USC + 1),
        .WIDTH_CYC(int'(MEAS_TRIGGER_MIN_WIDTH_US) * USC)) u_meas_ctrl_model (
        .mclk(mclk), .resetn(resetn), .fire(fire),
        .measTrigger(measTrigger)
    );

    // ==========================================================
    // clock, edge monitor, fault stimulus
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;
    // pin settled since the falling edge; end flag may already be low
    always @(posedge mclk) begin
        if (measTrigger === 1'b0 && prevTrig === 1'b1) begin
            pinFall = cyc;
        end
        prevTrig = measTrigger;
    end
    always @(negedge mclk) begin
        if (eoc === 1'b1 && prevEoc === 1'b0) begin
            eocRise = cyc;
            nEocRise++;
        end
        if (eoc === 1'b0 && prevEoc === 1'b1) begin
            eocFall = cyc;
            nEocFall++;
        end
        if (removalReady === 1'b1 && prevRr === 1'b0) begin
            rrRise = cyc;
            nRrRise++;
        end
        if (removalReady === 1'b0 && prevRr === 1'b1) begin
            rrFall = cyc;
            nRrFall++;
        end
        prevEoc = eoc;
        prevRr = removalReady;
    end
    // plan 1 faults mid measuring, plan 2 only inside the delay
    always @(negedge mclk) begin
        probeFault <= liveFault
            | (faultPlan == 1 && !removalReady
               && ((cyc - rrFall) inside {[50:59]}))
            | (faultPlan == 2 && !eoc && removalReady
               && ((cyc - eocFall) inside {[10:20]}));
    end

    // ==========================================================
    // reference model and helpers
    function automatic int measExp(mode_t m, rate_t r, logic l60, int n);
        int base;
        int ovh;
        logic dl;
        dl = (m == MODE_DUAL);
        case (r)
            RATE_FASTEST: base = dl ? MEAS_D_FASTEST_US : MEAS_S_FASTEST_US;
            RATE_FAST: base = dl ? MEAS_D_FAST_US : MEAS_S_FAST_US;
            default: begin
                base = dl ? (l60 ? MEAS_D_MED60_US : MEAS_D_MED50_US)
                    : (l60 ? MEAS_S_MED60_US : MEAS_S_MED50_US);
            end
        endcase
        ovh = dl ? OVH_D_US : OVH_S_US;
        return ((base - ovh) * n + ovh) * USC;
    endfunction

    function automatic int cnt(int sel);
        return (sel == 0) ? nEocRise : (sel == 1) ? nEocFall : nRrRise;
    endfunction

    task automatic stopTest();
        if (errCount == 0 && nTests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic waitCnt(input int sel, input int target, input int bound);
        int k;
        k = 0;
        while (cnt(sel) < target && k < bound) begin
            @(negedge mclk);
            k++;
        end
        if (cnt(sel) < target) begin
            errCount++;
            $display("Error at %0t: wait got %h expected %h", $time,
                cnt(sel), target);
            stopTest();
        end
    endtask

    // one external cycle: delay, measuring and calculation intervals, pass, fault and the judgments of the active mode against the model
    task automatic trigCycle(input logic expFault);
        int e0;
        int ms;
        int cc;
        logic ip;
        judge_t rj;
        judge_t vj;
        e0 = nEocRise;
        rj = judge_t'(3'h1 << ($urandom % 3));
        vj = judge_t'(3'h1 << ($urandom % 3));
        resJudge <= rj;
        voltJudge <= vj;
        ms = measExp(cfg.mode, cfg.rate, cfg.line60,
            (avgCount == 0) ? 1 : int'(avgCount));
        cc = (CALC_BASE_US + (cfg.statsOn ? CALC_STATS_US : 0)
            + (cfg.refTol ? CALC_REFTOL_US : 0)) * USC;
        case (cfg.mode)
            MODE_DUAL: ip = rj.inRange & vj.inRange;
            MODE_RES: ip = rj.inRange;
            default: ip = vj.inRange;
        endcase
        fire <= 1'b1;
        @(negedge mclk);
        fire <= 1'b0;
        waitCnt(0, e0 + 1, 40000);
        check(rrFall - pinFall, delayUs * USC + SYNC_STAGES + 1);
        check(rrRise - rrFall, ms);
        check(eocRise - rrRise, cc);
        check(32'(combinedPass), 32'(ip));
        check(32'(faultOut), 32'(expFault));
        if (cfg.mode != MODE_VOLT) check(32'(resOut), 32'(rj));
        if (cfg.mode != MODE_RES) check(32'(voltOut), 32'(vj));
    endtask

    // ==========================================================
    // main sequence
    initial begin
        resetn = 1'b0;
        cfg = '0;
        cfg.extTrigger = 1'b1;
        avgCount = 8'h01;
        eocPulseMs = 8'h02;
        delayUs = 20'h00005;
        {calActive, gpWrite, fire, liveFault} = 4'h0;
        resJudge = '0;
        voltJudge = '0;
        gpData = '0;
        errCount = 0;
        nTests = 0;
        faultPlan = 0;
        void'($urandom(32'h64eb9518));
        repeat (6) @(negedge mclk);
        check({eoc, removalReady, faultOut}, 3'h6);
        resetn <= 1'b1;
        @(negedge mclk);
        check({eoc, removalReady}, 2'h3);
        for (int i = 0; i < 6; i++) begin
            d = 10'($urandom);
            gpData <= d;
            gpWrite <= 1'b1;
            @(negedge mclk);
            gpWrite <= 1'b0;
            gpData <= ~d;
            @(negedge mclk);
            check(32'(gpOutputs), 32'(d));
        end
        trigCycle(1'b0);
        repeat (100) @(negedge mclk);
        check(32'(eoc), 32'h1);
        cfg.mode = MODE_DUAL;
        cfg.statsOn = 1'b1;
        cfg.refTol = 1'b1;
        avgCount = 8'h02;
        faultPlan = 1;
        trigCycle(1'b1);
        cfg = '{1'b1, 1'b0, 1'b0, RATE_MEDIUM, MODE_VOLT, 1'b1, 1'b0, 1'b0};
        avgCount = 8'h00;
        delayUs = 20'h000C8;
        faultPlan = 2;
        trigCycle(1'b0);
        faultPlan = 0;
        cfg = '{1'b1, 1'b0, 1'b0, RATE_FASTEST, MODE_RES, 1'b0, 1'b0, 1'b0};
        calActive = 1'b1;
        r0 = nRrFall;
        fire <= 1'b1;
        @(negedge mclk);
        fire <= 1'b0;
        repeat (3700) @(negedge mclk);
        check(nRrFall - r0, 0);
        check({eoc, removalReady}, 2'h3);
        calActive = 1'b0;
        trigCycle(1'b0);
        cfg.eocPulse = 1'b1;
        trigCycle(1'b0);
        waitCnt(1, nEocFall + 1, 2100);
        w = eocFall - eocRise;
        check(32'(w >= 1999 * USC && w <= 2001 * USC), 32'h1);
        cfg.faultModeLive = 1'b1;
        for (int i = 0; i < 4; i++) begin
            liveFault <= i[0] ^ 1'b1;
            repeat (6) @(negedge mclk);
            check(32'(faultOut), 32'(i[0] ^ 1'b1));
        end
        liveFault <= 1'b0;
        cfg = '{1'b0, 1'b0, 1'b0, RATE_FASTEST, MODE_RES, 1'b0, 1'b0, 1'b0};
        avgCount = 8'h04;
        delayUs = 20'h00000;
        // a trigger pin edge lands in here and must change nothing
        fire <= 1'b1;
        @(negedge mclk);
        fire <= 1'b0;
        waitCnt(0, nEocRise + 1, 10000);
        waitCnt(1, nEocFall + 1, 1200);
        check(eocFall - eocRise, EOC_INT_FASTEST_US * USC + 1);
        waitCnt(2, nRrRise + 1, 5000);
        check(rrRise - rrFall, MEAS_S_FASTEST_US * USC);
        stopTest();
    end
endmodule

`default_nettype wire
